// File: rtl/wbc_pkg.sv
// constants, types and state layout of the watchdog and bus control registers
package wbc_pkg;
   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [6:0] WBC_ADDR_HW = 7'h02;
   localparam logic [6:0] WBC_ADDR_WD = 7'h03;
   localparam logic [6:0] WBC_ADDR_BUS = 7'h04;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int WBC_WD_CHECKSUM = 15;
   localparam int WBC_WD_STOP_DEACT = 6;
   localparam int WBC_WD_STYLE = 5;
   localparam int WBC_WD_BUS_WAKE = 4;
   localparam int WBC_WD_PERIOD_LO = 0;
   localparam int WBC_BUS_FLASH = 7;
   localparam int WBC_BUS_LOW_SLOPE = 6;
   localparam int WBC_BUS_TX_TIMEOUT = 5;
   localparam int WBC_BUS_MODE_LO = 3;
   localparam int WBC_HW_STOP_DEACT = 2;
   // ----------------------------------------------------------------
   // writable masks and load values
   // ----------------------------------------------------------------
   localparam logic [15:0] WBC_WD_MASK = 16'h8077;
   localparam logic [15:0] WBC_BUS_MASK = 16'h00f8;
   localparam logic [15:0] WBC_HW_MASK = 16'h0004;
   localparam logic [15:0] WBC_WD_RESET = 16'h0014;
   localparam logic [15:0] WBC_WD_RESTART = 16'h0004;
   localparam logic [15:0] WBC_WD_RESTART_KEEP = 16'h0010;
   localparam logic [15:0] WBC_BUS_RESET = 16'h0000;
   localparam logic [15:0] WBC_BUS_DEV_RESET = 16'h0018;
   localparam logic [15:0] WBC_BUS_RESTART_KEEP = 16'h00c0;
   localparam logic [15:0] WBC_BUS_FAILSAFE_KEEP = 16'h00e0;
   localparam logic [15:0] WBC_BUS_FAILSAFE = 16'h0008;
   localparam logic [15:0] WBC_HW_RESET = 16'h0000;
   localparam logic [13:0] WBC_PERIOD_RESET = 14'd200;
   // ----------------------------------------------------------------
   // serial frame
   // ----------------------------------------------------------------
   localparam logic [4:0] WBC_FRAME_BITS = 5'd24;
   localparam logic [4:0] WBC_ADDR_BITS = 5'd8;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      WBC_IDLE = 1'b0,
      WBC_SHIFT = 1'b1
   } wbc_frame_t;

   typedef struct packed {
      logic checksum;
      logic stopDeactBit0;
      logic supervisionStyle;
      logic startAfterBusWake;
      logic [2:0] supervisionPeriod;
   } wbc_supervision_style_t;

   typedef struct packed {
      logic slopeOff;
      logic lowSlopeSelect;
      logic transmitTimeoutEnable;
      logic [1:0] linMode;
   } wbc_bus_cfg_t;

   typedef struct packed {
      logic [1:0] csSync;
      logic [1:0] sckSync;
      logic [1:0] mosiSync;
      logic sckPrev;
      wbc_frame_t frame;
      logic [4:0] bitCnt;
      logic [23:0] shIn;
      logic [15:0] shOut;
      logic miso;
      logic [15:0] wd;
      logic [15:0] bus;
      logic [15:0] hw;
      logic porPend;
      logic [13:0] periodMs;
   } wbc_state_t;
endpackage

// File: rtl/wbc_regs.sv
// serial-access watchdog and bus transceiver control registers
`timescale 1ns/1ps

// Overview of operation
// - bit 15 of watchdog control is a stored checksum bit, counted as 0 or 1
// - unused bits of both control registers always read back as zero
// - watchdog bit 6 deactivates watchdog in stop mode; hardware can set it
// - watchdog bit 5 chooses time-out (0) or window (1) supervision
// - watchdog bit 4 enables start with long open window after bus wake
// - watchdog bits 2:0 pick period 10,20,50,100,200,500 ms, 1 s, 10 s
// - power-on or soft reset loads watchdog control with 0x0014
// - restart loads 0x0004 into watchdog control, keeping the bus-wake bit
// - bus bit 7 turns slope control off for rates up to 115 kBaud
// - bus bit 6 selects low-slope mode for 10.4 kBaud
// - bus bit 5 enables transmit-data time-out supervision
// - bus control clears on reset outside development mode; restart keeps slopes, mode by cause
// - fail-safe entry rewrites bus control so transceiver is wake capable
// - in software development mode reset loads transceiver mode normal
// - second stop deactivation bit clears on stop to normal change
// - a write frame shifts out the previously programmed content
module wbc_regs
   import wbc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spiCsN,
   input wire logic spiSck,
   input wire logic spiMosi,
   output logic spiMiso,
   output logic spiMisoOe,
   input wire logic softReset,
   input wire logic restartEntry,
   input wire logic failSafeEntry,
   input wire logic swDevMode,
   input wire logic stopToNormal,
   input wire logic hwStopDeactSet,
   input wire logic hwLinModeLoad,
   input wire logic [1:0] hwLinMode,
   input wire logic [1:0] restartLinMode,
   output wbc_supervision_style_t wdCfg,
   output wbc_bus_cfg_t busCfg,
   output logic stopDeactBit1,
   output logic [13:0] periodMs
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [13:0] periodOf(input logic [2:0] code);
      logic [13:0] ms;
      ms = 14'h0000;
      case (code)
         3'h0: ms = 14'd10;
         3'h1: ms = 14'd20;
         3'h2: ms = 14'd50;
         3'h3: ms = 14'd100;
         3'h4: ms = 14'd200;
         3'h5: ms = 14'd500;
         3'h6: ms = 14'd1000;
         default: ms = 14'd10000;
      endcase
      return ms;
   endfunction

   function automatic logic [15:0] readBack(input logic [6:0] addr,
                                            input wbc_state_t st);
      logic [15:0] v;
      v = 16'h0000;
      case (addr)
         WBC_ADDR_WD: v = st.wd & WBC_WD_MASK;
         WBC_ADDR_BUS: v = st.bus & WBC_BUS_MASK;
         WBC_ADDR_HW: v = st.hw & WBC_HW_MASK;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   wbc_state_t s;
   wbc_state_t n;
   logic csN;
   logic sck;
   logic din;
   logic rise;
   logic fall;
   logic doWrite;
   logic [6:0] wrAddr;
   logic [15:0] wrData;

   always_comb begin
      n = s;
      doWrite = 1'b0;
      n.csSync = {s.csSync[0], spiCsN};
      n.sckSync = {s.sckSync[0], spiSck};
      n.mosiSync = {s.mosiSync[0], spiMosi};
      csN = s.csSync[1];
      sck = s.sckSync[1];
      din = s.mosiSync[1];
      rise = sck & ~s.sckPrev;
      fall = ~sck & s.sckPrev;
      n.sckPrev = sck;
      wrAddr = s.shIn[22:16];
      wrData = s.shIn[15:0];

      // ----------------------------------------------------------------
      // serial frame
      // ----------------------------------------------------------------
      case (s.frame)
         WBC_IDLE: begin
            if (!csN) begin
               n.frame = WBC_SHIFT;
               n.bitCnt = 5'd0;
               n.shIn = 24'h000000;
               n.shOut = 16'h0000;
               n.miso = 1'b0;
            end
         end
         WBC_SHIFT: begin
            if (csN) begin
               n.frame = WBC_IDLE;
               doWrite = (s.bitCnt == WBC_FRAME_BITS) & s.shIn[23];
            end else begin
               if (rise && s.bitCnt != WBC_FRAME_BITS) begin
                  n.shIn = {s.shIn[22:0], din};
                  n.bitCnt = s.bitCnt + 5'd1;
                  if (s.bitCnt == WBC_ADDR_BITS - 5'd1) begin
                     n.shOut = readBack({s.shIn[5:0], din}, s);
                  end
               end
               if (fall && s.bitCnt >= WBC_ADDR_BITS) begin
                  n.miso = s.shOut[15];
                  n.shOut = {s.shOut[14:0], 1'b0};
               end
            end
         end
         default: n.frame = WBC_IDLE;
      endcase

      // ----------------------------------------------------------------
      // register writes
      // ----------------------------------------------------------------
      if (doWrite) begin
         case (wrAddr)
            WBC_ADDR_WD: n.wd = wrData & WBC_WD_MASK;
            WBC_ADDR_BUS: n.bus = wrData & WBC_BUS_MASK;
            WBC_ADDR_HW: n.hw = wrData & WBC_HW_MASK;
            default: n.hw = s.hw;
         endcase
      end

      // ----------------------------------------------------------------
      // hardware updates, winning over a write in the same cycle
      // ----------------------------------------------------------------
      if (hwStopDeactSet) begin
         n.wd[WBC_WD_STOP_DEACT] = 1'b1;
      end
      if (hwLinModeLoad) begin
         n.bus[WBC_BUS_MODE_LO +: 2] = hwLinMode;
      end
      if (stopToNormal) begin
         n.hw[WBC_HW_STOP_DEACT] = 1'b0;
      end

      // ----------------------------------------------------------------
      // mode entries and resets
      // ----------------------------------------------------------------
      if (failSafeEntry) begin
         n.bus = (s.bus & WBC_BUS_FAILSAFE_KEEP) | WBC_BUS_FAILSAFE;
      end
      if (restartEntry) begin
         n.wd = WBC_WD_RESTART | (s.wd & WBC_WD_RESTART_KEEP);
         n.bus = s.bus & WBC_BUS_RESTART_KEEP;
         n.bus[WBC_BUS_MODE_LO +: 2] = restartLinMode;
         n.hw = WBC_HW_RESET;
      end
      if (softReset || s.porPend) begin
         n.wd = WBC_WD_RESET;
         n.bus = swDevMode ? WBC_BUS_DEV_RESET : WBC_BUS_RESET;
         n.hw = WBC_HW_RESET;
      end
      n.porPend = 1'b0;
      n.periodMs = periodOf(n.wd[WBC_WD_PERIOD_LO +: 3]);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '0;
         s.csSync <= 2'h3;
         s.mosiSync <= 2'h0;
         s.frame <= WBC_IDLE;
         s.wd <= WBC_WD_RESET;
         s.bus <= WBC_BUS_RESET;
         s.hw <= WBC_HW_RESET;
         s.porPend <= 1'b1;
         s.periodMs <= WBC_PERIOD_RESET;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign spiMiso = s.miso;
   assign spiMisoOe = (s.frame == WBC_SHIFT);
   assign wdCfg.checksum = s.wd[WBC_WD_CHECKSUM];
   assign wdCfg.stopDeactBit0 = s.wd[WBC_WD_STOP_DEACT];
   assign wdCfg.supervisionStyle = s.wd[WBC_WD_STYLE];
   assign wdCfg.startAfterBusWake = s.wd[WBC_WD_BUS_WAKE];
   assign wdCfg.supervisionPeriod = s.wd[WBC_WD_PERIOD_LO +: 3];
   assign busCfg.slopeOff = s.bus[WBC_BUS_FLASH];
   assign busCfg.lowSlopeSelect = s.bus[WBC_BUS_LOW_SLOPE];
   assign busCfg.transmitTimeoutEnable = s.bus[WBC_BUS_TX_TIMEOUT];
   assign busCfg.linMode = s.bus[WBC_BUS_MODE_LO +: 2];
   assign stopDeactBit1 = s.hw[WBC_HW_STOP_DEACT];
   assign periodMs = s.periodMs;

endmodule

// File: verification/wbc_regs_monitor.sv
// assertion checker for the control register block
`timescale 1ns/1ps
module wbc_regs_monitor
   import wbc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic softReset,
   input wire logic restartEntry,
   input wire logic failSafeEntry,
   input wire logic swDevMode,
   input wire logic stopToNormal,
   input wire logic hwStopDeactSet,
   input wire logic [1:0] restartLinMode,
   input wire wbc_supervision_style_t wdCfg,
   input wire wbc_bus_cfg_t busCfg,
   input wire logic stopDeactBit1,
   input wire logic [13:0] periodMs
);
   localparam logic [13:0] MS [8] = '{14'h000a, 14'h0014, 14'h0032,
      14'h0064, 14'h00c8, 14'h01f4, 14'h03e8, 14'h2710};
   logic rs;
   assign rs = restartEntry && !softReset;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_SOFT_WD: assert property (softReset |=> wdCfg == 7'h0c)
      else $error("wd reset load");
   AST_SOFT_BUS: assert property (softReset |=>
      busCfg == {3'b000, {2{$past(swDevMode)}}}) else $error("bus reset");
   AST_RST_WD: assert property (rs |=> wdCfg ==
      {3'b000, $past(wdCfg.startAfterBusWake), 3'b100})
      else $error("wd restart");
   AST_RST_BUS: assert property (rs |=> busCfg ==
      {$past(busCfg[4:3]), 1'b0, $past(restartLinMode)})
      else $error("bus restart");
   AST_FAIL: assert property (
      failSafeEntry && !restartEntry && !softReset
      |=> busCfg == {$past(busCfg[4:2]), 2'b01}) else $error("fail-safe");
   AST_HW_SET: assert property (
      hwStopDeactSet && !restartEntry && !softReset
      |=> wdCfg.stopDeactBit0) else $error("hw stop set");
   AST_STOP: assert property (stopToNormal |=> !stopDeactBit1)
      else $error("stop bit1 kept");
   AST_PERIOD: assert property (
      periodMs == MS[wdCfg.supervisionPeriod]) else $error("period decode");
endmodule
bind wbc_regs wbc_regs_monitor i_mon (.clk, .sys_rst, .softReset,
   .restartEntry, .failSafeEntry, .swDevMode, .stopToNormal,
   .hwStopDeactSet, .restartLinMode, .wdCfg, .busCfg, .stopDeactBit1,
   .periodMs);

// File: verification/wbc_host.sv
// host controller model driving serial register frames
`timescale 1ns/1ps
module wbc_host (
   input wire logic clk,
   output logic spiCsN,
   output logic spiSck,
   output logic spiMosi,
   input wire logic spiMiso
);
   initial begin
      spiCsN = 1'b1;
      spiSck = 1'b0;
      spiMosi = 1'b0;
   end
   // one 24-bit frame, msb first, miso taken before each of the last 16 rises
   task automatic xfer(input logic [23:0] f, output logic [15:0] d);
      d = 16'h0000;
      #1 spiCsN = 1'b0;
      repeat (6) @(posedge clk);
      for (int i = 23; i >= 0; i--) begin
         #1 spiMosi = f[i];
         repeat (6) @(posedge clk);
         #1 if (i < 16) d[i] = spiMiso;
         spiSck = 1'b1;
         repeat (6) @(posedge clk);
         #1 spiSck = 1'b0;
      end
      repeat (6) @(posedge clk);
      #1 spiCsN = 1'b1;
      spiMosi = ~spiMosi;
      repeat (6) @(posedge clk);
   endtask
endmodule

// File: verification/tb_wbc_regs.sv
// self-checking bench for the control register block
`timescale 1ns/1ps
module tb_wbc_regs
   import wbc_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic spiCsN, spiSck, spiMosi, spiMiso, spiMisoOe, stopDeactBit1;
   logic [5:0] pulses = 6'h00;
   logic swDevMode = 1'b0;
   logic [1:0] hwLinMode = 2'h0;
   logic [1:0] restartLinMode = 2'h0;
   wbc_supervision_style_t wdCfg;
   wbc_bus_cfg_t busCfg;
   logic [13:0] periodMs;
   int n_errors = 0;
   int samples_checked = 0;
   wbc_host i_host (.clk, .spiCsN, .spiSck, .spiMosi,
      .spiMiso(spiMisoOe ? spiMiso : ~spiMiso));
   wbc_regs i_dut (.clk, .sys_rst, .spiCsN, .spiSck, .spiMosi, .spiMiso,
      .spiMisoOe, .softReset(pulses[5]), .restartEntry(pulses[4]),
      .failSafeEntry(pulses[3]), .stopToNormal(pulses[2]),
      .hwStopDeactSet(pulses[1]), .hwLinModeLoad(pulses[0]), .swDevMode,
      .hwLinMode, .restartLinMode, .wdCfg, .busCfg, .stopDeactBit1,
      .periodMs);
   always #10 clk = ~clk;
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] e,
      input string nm);
      logic [15:0] d;
      @(posedge clk);
      i_host.xfer({1'b0, a, 16'h0000}, d);
      chk(nm, e, d);
      chk("miso enable", 16'h0000, {15'h0000, spiMisoOe});
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] v,
      input logic [15:0] old);
      logic [15:0] d;
      @(posedge clk);
      i_host.xfer({1'b1, a, v}, d);
      chk("write echo", old, d);
   endtask
   // strobe order: soft, restart, fail-safe, stop->normal, set, load
   task automatic pulse(input logic [5:0] m);
      @(posedge clk);
      #1 pulses = m;
      @(posedge clk);
      #1 pulses = 6'h00;
   endtask
   task automatic t_reset;
      rd(WBC_ADDR_WD, 16'h0014, "wd reset");
      rd(WBC_ADDR_BUS, 16'h0000, "bus reset");
      chk("period", 16'h00c8, {2'b00, periodMs});
   endtask
   task automatic t_write;
      wr(WBC_ADDR_WD, 16'hffff, 16'h0014);
      rd(WBC_ADDR_WD, 16'h8077, "wd ones");
      chk("wd fields", 16'h007f, {9'h000, wdCfg});
      chk("period", 16'h2710, {2'b00, periodMs});
      wr(WBC_ADDR_BUS, 16'hffff, 16'h0000);
      rd(WBC_ADDR_BUS, 16'h00f8, "bus ones");
      chk("bus fields", 16'h001f, {11'h000, busCfg});
      wr(7'h10, 16'hffff, 16'h0000);
      rd(7'h10, 16'h0000, "unmapped");
      wr(WBC_ADDR_WD, 16'h0003, 16'h8077);
      chk("period", 16'h0064, {2'b00, periodMs});
      chk("wd fields", 16'h0003, {9'h000, wdCfg});
   endtask
   task automatic t_hw;
      #1 restartLinMode = 2'b10;
      pulse(6'h10);
      rd(WBC_ADDR_WD, 16'h0004, "wd restart");
      rd(WBC_ADDR_BUS, 16'h00d0, "bus restart");
      pulse(6'h08);
      rd(WBC_ADDR_BUS, 16'h00c8, "bus fail-safe");
      #1 hwLinMode = 2'b11;
      pulse(6'h01);
      rd(WBC_ADDR_BUS, 16'h00d8, "bus hw mode");
      pulse(6'h02);
      rd(WBC_ADDR_WD, 16'h0044, "wd hw stop");
      wr(WBC_ADDR_HW, 16'h0004, 16'h0000);
      chk("stop bit1", 16'h0001, {15'h0000, stopDeactBit1});
      pulse(6'h04);
      chk("stop bit1", 16'h0000, {15'h0000, stopDeactBit1});
      swDevMode = 1'b1;
      pulse(6'h20);
      rd(WBC_ADDR_WD, 16'h0014, "wd soft");
      rd(WBC_ADDR_BUS, 16'h0018, "bus dev mode");
   endtask
   task automatic t_por;
      wr(WBC_ADDR_WD, 16'h0025, 16'h0014);
      wr(WBC_ADDR_BUS, 16'h00e0, 16'h0018);
      chk("period", 16'h01f4, {2'b00, periodMs});
      @(posedge clk);
      #1 sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      repeat (3) @(posedge clk);
      rd(WBC_ADDR_WD, 16'h0014, "wd por");
      rd(WBC_ADDR_BUS, 16'h0018, "bus dev por");
      pulse(6'h10);
      rd(WBC_ADDR_WD, 16'h0014, "wd restart keep");
      rd(WBC_ADDR_BUS, 16'h0010, "bus restart mode");
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 sys_rst = 1'b0;
      repeat (3) @(posedge clk);
      t_reset;
      t_write;
      t_hw;
      t_por;
      test_done;
   end
   initial begin
      #1_000_000;
      n_errors++;
      test_done;
   end
endmodule
